/* shared/cis_params.svh */
// constants for the comparator input select block
`ifndef CIS_PARAMS_SVH
`define CIS_PARAMS_SVH
`define CIS_CHSEL_W         5
`define CIS_LAST_CHANNEL    5'h0A
`define CIS_SHARED_CHANNEL  5'h03
`define CIS_DIV_W           2
`define CIS_REFSRC_INTERNAL 2'h3
`define CIS_CTRLB_MUXEN_BIT 6
`define CIS_CTRLB_DIV_HI    5
`define CIS_CTRLB_DIV_LO    4
`define CIS_CSR_IREF_BIT    6
`define CIS_CSR_RESULT_BIT  5
`define CIS_CTRLB_RESET     8'h00
`define CIS_CSR_RESET       8'h00
`define CIS_NUM_CHANNELS    11
`endif

/* shared/cis_pkg.sv */
// types for the comparator input select block
package cis_pkg;
	typedef enum logic [1:0] {
		CIS_NEG_PIN,
		CIS_NEG_INTERNAL,
		CIS_NEG_RESERVED
	} cis_neg_src_e;
	typedef enum logic [1:0] {
		CIS_POS_PIN,
		CIS_POS_CHANNEL,
		CIS_POS_UNDEFINED
	} cis_pos_src_e;
endpackage

/* design/cis_comparator_input_select.sv */
// comparator input selection and result synchroniser
`timescale 1ns/1ps
`include "cis_params.svh"

// =====================================================================
// module
// Notes on behaviour
// R1: mux enable set and converter off route selected channel to positive input.
// R2: mux enable clear or converter on selects the dedicated positive pin.
// R3: codes 0 to 10 pick channels 0 to 10; others undefined.
// R4: code 3 picks channel 3, shared with the current source pin.
// R5: internal reference select clear applies dedicated negative pin.
// R6: internal reference select set uses divided internal reference as negative input.
// R7: divider codes 00 to 11 give full, half, quarter, eighth reference.
// R8: software must set reference source to 11 for internal reference.
// R9: mux enable is read/write bit 6 of control B, reset zero.
// R10: divider select is bits 5:4 of control B, read/write, reset zero.
// R11: internal reference select is bit 6 of comparator status, reset zero.
// R12: comparator result is synchronised, one to two cycles of latency.
// R13: selections decode from registered bits, effective cycle after write.
module cis_comparator_input_select
	import cis_pkg::*;
(
	// clock and reset
	input  wire logic                     clock,
	input  wire logic                     reset,
	// control register b write port
	input  wire logic                     ctrl_b_write,
	input  wire logic [7:0]               ctrl_b_wdata,
	output logic      [7:0]               ctrl_b_rdata,
	// comparator status register write port
	input  wire logic                     comp_csr_write,
	input  wire logic [7:0]               comp_csr_wdata,
	output logic      [7:0]               comp_csr_rdata,
	// converter state
	input  wire logic                     converter_enable,
	input  wire logic [`CIS_CHSEL_W-1:0]  channel_select,
	input  wire logic [1:0]               reference_source_select,
	// analog comparator core
	input  wire logic                     comparator_raw,
	// positive input selection
	output logic                          pos_use_channel,
	output logic [`CIS_NUM_CHANNELS-1:0]  pos_channel_onehot,
	// negative input selection
	output logic                          neg_use_internal,
	output logic [`CIS_DIV_W-1:0]         neg_divider,
	output logic                          neg_reserved,
	output cis_pos_src_e                  pos_source,
	output cis_neg_src_e                  neg_source,
	output logic                          comparator_result
);

	// =================================================================
	// decode helpers
	// true for the channel codes that name a real converter input
	function automatic logic cis_channel_ok(
		input logic [`CIS_CHSEL_W-1:0] code
	);
		return code <= `CIS_LAST_CHANNEL; // see R3
	endfunction

	// one-hot channel vector; undefined codes connect nothing
	function automatic logic [`CIS_NUM_CHANNELS-1:0] cis_channel_onehot(
		input logic [`CIS_CHSEL_W-1:0] code
	);
		logic [`CIS_NUM_CHANNELS-1:0] hot;
		hot = '0;
		unique case (code)
			5'h00:   hot[0]  = 1'h1;
			5'h01:   hot[1]  = 1'h1;
			5'h02:   hot[2]  = 1'h1;
			// code 3 lands on the pin shared with the current source
			`CIS_SHARED_CHANNEL: hot[3] = 1'h1; // see R4
			5'h04:   hot[4]  = 1'h1;
			5'h05:   hot[5]  = 1'h1;
			5'h06:   hot[6]  = 1'h1;
			5'h07:   hot[7]  = 1'h1;
			5'h08:   hot[8]  = 1'h1;
			5'h09:   hot[9]  = 1'h1;
			5'h0A:   hot[10] = 1'h1;
			default: hot     = '0;
		endcase
		return hot;
	endfunction

	// control b readback image; unmapped bits read zero
	function automatic logic [7:0] cis_ctrl_b_image(
		input logic                  mux_en,
		input logic [`CIS_DIV_W-1:0] div
	);
		logic [7:0] image;
		image = `CIS_CTRLB_RESET;
		image[`CIS_CTRLB_MUXEN_BIT] = mux_en;
		image[`CIS_CTRLB_DIV_HI:`CIS_CTRLB_DIV_LO] = div;
		return image;
	endfunction

	// comparator status readback image; unmapped bits read zero
	function automatic logic [7:0] cis_csr_image(
		input logic iref,
		input logic result
	);
		logic [7:0] image;
		image = `CIS_CSR_RESET;
		image[`CIS_CSR_IREF_BIT]   = iref;
		image[`CIS_CSR_RESULT_BIT] = result;
		return image;
	endfunction

	// =================================================================
	// control bits
	logic                   mux_enable_reg, mux_enable_next;
	logic [`CIS_DIV_W-1:0]  div_sel_reg, div_sel_next;
	logic                   iref_sel_reg, iref_sel_next;

	always_comb begin
		mux_enable_next = mux_enable_reg;
		div_sel_next    = div_sel_reg;
		iref_sel_next   = iref_sel_reg;
		if (ctrl_b_write) begin
			mux_enable_next = ctrl_b_wdata[`CIS_CTRLB_MUXEN_BIT]; // see R9
			div_sel_next    = ctrl_b_wdata[`CIS_CTRLB_DIV_HI:`CIS_CTRLB_DIV_LO]; // see R10
		end
		if (comp_csr_write) begin
			iref_sel_next = comp_csr_wdata[`CIS_CSR_IREF_BIT]; // see R11
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			mux_enable_reg <= 1'h0;
			div_sel_reg    <= '0;
			iref_sel_reg   <= 1'h0;
		end else begin
			mux_enable_reg <= mux_enable_next;
			div_sel_reg    <= div_sel_next;
			iref_sel_reg   <= iref_sel_next;
		end
	end

	// =================================================================
	// comparator result synchroniser
	// the raw comparator can move at any time, so two flops guard it
	logic                   sync1_reg, sync1_next;
	logic                   sync2_reg, sync2_next;

	always_comb begin
		sync1_next = comparator_raw;
		sync2_next = sync1_reg; // see R12
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			sync1_reg <= 1'h0;
			sync2_reg <= 1'h0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
		end
	end

	assign comparator_result = sync2_reg; // see R12

	// =================================================================
	// read back
	always_comb begin
		ctrl_b_rdata   = cis_ctrl_b_image(mux_enable_reg, div_sel_reg); // see R9, R10
		comp_csr_rdata = cis_csr_image(iref_sel_reg, sync2_reg); // see R11, R12
	end

	// =================================================================
	// positive input select, decoded from registered bits
	always_comb begin
		pos_channel_onehot = '0;
		pos_use_channel    = 1'h0;
		pos_source         = CIS_POS_PIN; // see R2
		if (mux_enable_reg && !converter_enable) begin // see R1, R13
			if (cis_channel_ok(channel_select)) begin // see R3
				pos_use_channel    = 1'h1;
				pos_source         = CIS_POS_CHANNEL;
				pos_channel_onehot = cis_channel_onehot(channel_select); // see R4
			end else begin
				// undefined codes connect no channel at all
				pos_source = CIS_POS_UNDEFINED;
			end
		end
	end

	// =================================================================
	// negative input select
	always_comb begin
		neg_use_internal = 1'h0;
		neg_reserved     = 1'h0;
		neg_divider      = '0;
		neg_source       = CIS_NEG_PIN; // see R5
		if (iref_sel_reg) begin // see R13
			unique case (reference_source_select)
				`CIS_REFSRC_INTERNAL: begin // see R8
					neg_use_internal = 1'h1;
					neg_divider      = div_sel_reg; // see R6, R7
					neg_source       = CIS_NEG_INTERNAL;
				end
				default: begin
					// the other source codes give no defined negative input
					neg_reserved = 1'h1;
					neg_source   = CIS_NEG_RESERVED;
				end
			endcase
		end
	end

endmodule // cis_comparator_input_select

/* sim/cis_chk.sv */
// checker for the comparator input select
`timescale 1ns/1ps
// ====
module cis_chk (
	input wire logic clock, reset, ctrl_b_write, comp_csr_write, converter_enable, comparator_raw,
	input wire logic pos_use_channel, neg_use_internal, neg_reserved,
	input wire logic [7:0] ctrl_b_wdata, ctrl_b_rdata, comp_csr_wdata, comp_csr_rdata,
	input wire logic [4:0] channel_select, input wire logic [10:0] pos_channel_onehot,
	input wire logic [1:0] reference_source_select, neg_divider);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	wire logic iref = comp_csr_rdata[6], src3 = reference_source_select == 2'h3;
	wire logic [10:0] hot = 11'h001 << channel_select;
	sequence raw_rise; $rose(comparator_raw) ##1 comparator_raw; endsequence
	a_pos_mux: assert property (
		pos_use_channel == (ctrl_b_rdata[6] && !converter_enable && channel_select < 5'h0B))
		else $error("pos mux");
	a_pos_chan: assert property (
		pos_use_channel && channel_select < 5'h0B |-> pos_channel_onehot == hot) else $error("chan");
	a_neg_pin: assert property (
		!iref |-> !neg_use_internal && !neg_reserved) else $error("neg pin");
	a_neg_div: assert property (
		iref && src3 |-> neg_use_internal && neg_divider == ctrl_b_rdata[5:4]) else $error("div");
	a_neg_rsvd: assert property (
		neg_reserved == (iref && !src3)) else $error("reserved");
	a_b_write: assert property (
		ctrl_b_write |=> ctrl_b_rdata == ($past(ctrl_b_wdata) & 8'h70)) else $error("ctrl b");
	a_csr_write: assert property (
		comp_csr_write |=> iref == $past(comp_csr_wdata[6])) else $error("csr");
	a_sync_lat: assert property (
		raw_rise |-> ##1 comp_csr_rdata[5]) else $error("sync");
endmodule // cis_chk
bind cis_comparator_input_select cis_chk u_chk (.*);

/* sim/cis_core_model.sv */
// behavioural analog comparator core
`timescale 1ns/1ps
// ====
module cis_core_model (input wire logic clock, pos_above, output logic comparator_raw);
	always @(posedge clock) comparator_raw <= pos_above;
endmodule // cis_core_model

/* sim/comparator_input_select_tb.sv */
// self-checking bench for the comparator input select
`timescale 1ns/1ps
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("unexpected %0t mismatch", $time); end end
// ====
module comparator_input_select_tb;
	logic clock, reset, ctrl_b_write, comp_csr_write, converter_enable, pos_above, comparator_raw;
	logic pos_use_channel, neg_use_internal, neg_reserved, comparator_result;
	logic [10:0] pos_channel_onehot;
	logic [7:0] ctrl_b_wdata, comp_csr_wdata, ctrl_b_rdata, comp_csr_rdata;
	logic [4:0] channel_select;
	logic [1:0] reference_source_select, neg_divider, pos_source, neg_source;
	int errors, n_checks;
	// b, csr, enable, channel, source : use, onehot, internal, reserved, divider
	logic [59:0] r, rows [5] = '{60'h40_40_0_03_3_1_008_1_0_0,
		60'h50_40_1_03_3_0_000_1_0_1,
		60'h60_00_0_0A_3_1_400_0_0_0,
		60'h70_40_0_00_1_1_001_0_1_0,
		60'h30_40_0_00_3_0_000_1_0_3};
	cis_comparator_input_select dut (.*);
	cis_core_model core (.*);
	initial begin clock = 1'h0; forever #12.5 clock = ~clock; end
	task automatic wr(input logic [7:0] b, c);
		@(negedge clock) {ctrl_b_write, comp_csr_write, ctrl_b_wdata, comp_csr_wdata} = {2'h3, b, c};
		@(negedge clock) {ctrl_b_write, comp_csr_write} = 2'h0;
	endtask
	task end_of_test;
		if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		{reset, ctrl_b_write, comp_csr_write, converter_enable, pos_above} = 5'h10;
		{ctrl_b_wdata, comp_csr_wdata, channel_select, reference_source_select} = 23'h0;
		repeat (16) @(negedge clock);
		reset = 1'h0;
		`CK({ctrl_b_rdata, comp_csr_rdata}, 16'h0000)
		foreach (rows[k]) begin
			r = rows[k];
			wr(r[59:52], r[51:44]);
			{converter_enable, channel_select, reference_source_select} = {r[40], r[36:32], r[29:28]};
			#1 `CK({pos_use_channel, pos_channel_onehot}, {r[24], r[22:12]})
			`CK({neg_use_internal, neg_reserved, neg_divider}, {r[8], r[4], r[1:0]})
		end
		wr(8'hFF, 8'hFF);
		`CK({ctrl_b_rdata, comp_csr_rdata[6]}, 9'h0E1)
		`CK({pos_source, neg_source}, {cis_pkg::CIS_POS_CHANNEL, cis_pkg::CIS_NEG_INTERNAL})
		{channel_select, reference_source_select} = 7'h2C;
		#1 `CK({pos_use_channel, pos_channel_onehot, pos_source}, {12'h000, cis_pkg::CIS_POS_UNDEFINED})
		`CK({neg_reserved, neg_use_internal, neg_source}, {2'h2, cis_pkg::CIS_NEG_RESERVED})
		pos_above = 1'h1;
		repeat (2) @(negedge clock);
		`CK(comparator_result, 1'h0)
		@(negedge clock) `CK({comparator_result, comp_csr_rdata[5]}, 2'h3)
		@(negedge clock) reset = 1'h1;
		@(negedge clock) `CK({ctrl_b_rdata, comp_csr_rdata, comparator_result}, 17'h00000)
		reset = 1'h0;
		`CK({pos_source, neg_source}, {cis_pkg::CIS_POS_PIN, cis_pkg::CIS_NEG_PIN})
		@(negedge clock) `CK(comparator_result, 1'h0)
		@(negedge clock) `CK(comparator_result, 1'h1)
		end_of_test;
	end
endmodule // comparator_input_select_tb
